// ### tpl_pkg.sv
// package: preset indices, register widths, preset values, reset values
`default_nettype none
package tpl_pkg;

    localparam int TPL_REG_W = 32;
    localparam int TPL_IDX_W = 4;
    localparam int TPL_NUM_REGS = 6;
    localparam int TPL_STEP_W = 3;

    // protocol preset indices
    localparam logic [3:0] TPL_A106 = 4'h0;
    localparam logic [3:0] TPL_A212 = 4'h1;
    localparam logic [3:0] TPL_A424 = 4'h2;
    localparam logic [3:0] TPL_A848 = 4'h3;
    localparam logic [3:0] TPL_B106 = 4'h4;
    localparam logic [3:0] TPL_B212 = 4'h5;
    localparam logic [3:0] TPL_B424 = 4'h6;
    localparam logic [3:0] TPL_B848 = 4'h7;
    localparam logic [3:0] TPL_M212 = 4'h8;
    localparam logic [3:0] TPL_M424 = 4'h9;

    // target register slots, in write order
    localparam logic [2:0] TPL_SLOT_CLK = 3'h0;
    localparam logic [2:0] TPL_SLOT_MOD = 3'h1;
    localparam logic [2:0] TPL_SLOT_UND = 3'h2;
    localparam logic [2:0] TPL_SLOT_OVR = 3'h3;
    localparam logic [2:0] TPL_SLOT_DRV = 3'h4;
    localparam logic [2:0] TPL_SLOT_ANT = 3'h5;

    // preset values
    localparam logic [31:0] TPL_CLK_A106 = 32'h0000_0074;
    localparam logic [31:0] TPL_CLK_AHI = 32'h0000_0082;
    localparam logic [31:0] TPL_CLK_BLO = 32'h0000_008E;
    localparam logic [31:0] TPL_CLK_BHI = 32'h0000_078E;
    localparam logic [31:0] TPL_MOD_A1 = 32'h0000_2350;
    localparam logic [31:0] TPL_MOD_A424 = 32'h0000_0650;
    localparam logic [31:0] TPL_MOD_A848 = 32'h0000_0150;
    localparam logic [31:0] TPL_UND_A1 = 32'h0000_0017;
    localparam logic [31:0] TPL_UND_A424 = 32'h0000_0005;
    localparam logic [31:0] TPL_UND_A848 = 32'h0000_0001;
    localparam logic [31:0] TPL_OVR_B424 = 32'h01FE_0013;
    localparam logic [31:0] TPL_OVR_B848 = 32'h007E_000D;
    localparam logic [31:0] TPL_DRV_A106 = 32'h00DB_CF43;
    localparam logic [31:0] TPL_DRV_A212 = 32'h0DBC_F043;
    localparam logic [31:0] TPL_DRV_A848 = 32'h00F9_EF45;
    localparam logic [31:0] TPL_DRV_B106 = 32'h003A_4756;
    localparam logic [31:0] TPL_DRV_B212 = 32'h0039_C746;
    localparam logic [31:0] TPL_DRV_B424 = 32'h0071_CF54;
    localparam logic [31:0] TPL_DRV_B848 = 32'h0069_AF32;
    localparam logic [31:0] TPL_DRV_M212 = 32'h0039_E744;
    localparam logic [31:0] TPL_DRV_M424 = 32'h0039_EF33;
    localparam logic [31:0] TPL_ANT_ALL = 32'h0000_0010;
    localparam logic [31:0] TPL_ZERO = 32'h0000_0000;

    // value of each target register after reset
    localparam logic [31:0] TPL_RST_VAL = 32'h0000_0000;

    typedef enum logic [1:0] {
        TPL_IDLE = 2'b00,
        TPL_WRITE = 2'b01,
        TPL_DONE = 2'b10
    } tpl_state_e;

endpackage : tpl_pkg
`default_nettype wire

// ### tpl_rom_if.sv
// interface: preset lookup between sequencer and preset table
`timescale 1ns/1ns
`default_nettype none
interface tpl_rom_if;
    logic [3:0] index;
    logic [2:0] slot;
    logic [31:0] value;
    logic known;

    modport seq (output index, output slot, input value, input known);
    modport rom (input index, input slot, output value, output known);
endinterface : tpl_rom_if
`default_nettype wire

// ### tpl_preset_rom.sv
// module: combinational table of transmitter presets
`timescale 1ns/1ns
`default_nettype none
module tpl_preset_rom
    import tpl_pkg::*;
(
    // lookup port
    tpl_rom_if.rom rom
);

    function automatic logic [31:0] tpl_pick(
        input logic [2:0] slot,
        input logic [31:0] clk_v,
        input logic [31:0] mod_v,
        input logic [31:0] und_v,
        input logic [31:0] ovr_v,
        input logic [31:0] drv_v
    );
        logic [31:0] v;
        v = TPL_ANT_ALL;
        unique case (slot)
            TPL_SLOT_CLK: v = clk_v;
            TPL_SLOT_MOD: v = mod_v;
            TPL_SLOT_UND: v = und_v;
            TPL_SLOT_OVR: v = ovr_v;
            TPL_SLOT_DRV: v = drv_v;
            default: v = TPL_ANT_ALL;
        endcase
        return v;
    endfunction : tpl_pick

    always_comb begin
        rom.known = 1'b1;
        unique case (rom.index)
            TPL_A106: rom.value = tpl_pick(rom.slot, TPL_CLK_A106, TPL_MOD_A1, TPL_UND_A1,
                TPL_ZERO, TPL_DRV_A106);
            TPL_A212: rom.value = tpl_pick(rom.slot, TPL_CLK_AHI, TPL_MOD_A1, TPL_UND_A1,
                TPL_ZERO, TPL_DRV_A212);
            TPL_A424: rom.value = tpl_pick(rom.slot, TPL_CLK_AHI, TPL_MOD_A424, TPL_UND_A424,
                TPL_ZERO, TPL_DRV_A106);
            TPL_A848: rom.value = tpl_pick(rom.slot, TPL_CLK_AHI, TPL_MOD_A848, TPL_UND_A848,
                TPL_ZERO, TPL_DRV_A848);
            TPL_B106: rom.value = tpl_pick(rom.slot, TPL_CLK_BLO, TPL_ZERO, TPL_ZERO,
                TPL_ZERO, TPL_DRV_B106);
            TPL_B212: rom.value = tpl_pick(rom.slot, TPL_CLK_BLO, TPL_ZERO, TPL_ZERO,
                TPL_ZERO, TPL_DRV_B212);
            TPL_B424: rom.value = tpl_pick(rom.slot, TPL_CLK_BHI, TPL_ZERO, TPL_ZERO,
                TPL_OVR_B424, TPL_DRV_B424);
            TPL_B848: rom.value = tpl_pick(rom.slot, TPL_CLK_BHI, TPL_ZERO, TPL_ZERO,
                TPL_OVR_B848, TPL_DRV_B848);
            TPL_M212: rom.value = tpl_pick(rom.slot, TPL_CLK_BLO, TPL_ZERO, TPL_ZERO,
                TPL_ZERO, TPL_DRV_M212);
            TPL_M424: rom.value = tpl_pick(rom.slot, TPL_CLK_BLO, TPL_ZERO, TPL_ZERO,
                TPL_ZERO, TPL_DRV_M424);
            default: begin
                rom.value = TPL_ZERO;
                rom.known = 1'b0;
            end
        endcase
    end

endmodule : tpl_preset_rom
`default_nettype wire

// ### tpl_loader.sv
// module: transmitter preset loader, top level
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - request writes six transmitter registers from preset
// - type A 106 preset values
// - type A 212 preset values
// - type A 424 preset values
// - type A 848 preset values
// - type B 106 preset values
// - type B 212 preset values
// - type B 424 preset values
// - type B 848 preset values
// - Manchester 212 preset values
// - Manchester 424 preset values
module tpl_loader
    import tpl_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // request
    input wire logic load_protocol_preset_cmd_i,
    input wire logic [3:0] protocol_index_i,
    // status
    output logic busy_o,
    output logic done_o,
    output logic rejected_o,
    // transmitter configuration registers
    output logic [31:0] tx_carrier_clock_ctrl_o,
    output logic [31:0] tx_modulation_cfg_o,
    output logic [31:0] tx_undershoot_shape_o,
    output logic [31:0] tx_overshoot_shape_o,
    output logic [31:0] tx_driver_ctrl_o,
    output logic [31:0] antenna_ctrl_o
);

    ////////////////////////////////////////////////////////////////////////////////
    tpl_rom_if rom_bus ();

    tpl_preset_rom u_rom (
        .rom(rom_bus)
    );

    ////////////////////////////////////////////////////////////////////////////////
    tpl_state_e state;
    tpl_state_e next_state;
    logic [3:0] index;
    logic [3:0] next_index;
    logic [2:0] slot;
    logic [2:0] next_slot;
    logic done;
    logic next_done;
    logic rejected;
    logic next_rejected;
    logic busy;
    logic next_busy;
    logic [31:0] regs [TPL_NUM_REGS];
    logic [31:0] next_regs [TPL_NUM_REGS];

    assign rom_bus.index = index;
    assign rom_bus.slot = slot;

    always_comb begin
        next_state = state;
        next_index = index;
        next_slot = slot;
        next_done = 1'b0;
        next_rejected = 1'b0;
        next_regs = regs;
        unique case (state)
            TPL_IDLE: begin
                if (load_protocol_preset_cmd_i) begin
                    next_index = protocol_index_i;
                    next_slot = TPL_SLOT_CLK;
                    next_state = TPL_WRITE;
                end
            end
            TPL_WRITE: begin
                if (!rom_bus.known) begin
                    next_rejected = 1'b1;
                    next_state = TPL_IDLE;
                end else begin
                    next_regs[slot] = rom_bus.value;
                    if (slot == TPL_SLOT_ANT) begin
                        next_done = 1'b1;
                        next_state = TPL_DONE;
                    end else begin
                        next_slot = slot + 3'h1;
                    end
                end
            end
            TPL_DONE: begin
                next_state = TPL_IDLE;
            end
            default: begin
                next_state = TPL_IDLE;
            end
        endcase
        // busy is registered so that the port comes straight from a flop
        next_busy = (next_state != TPL_IDLE);
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= TPL_IDLE;
            index <= 4'h0;
            slot <= 3'h0;
            done <= 1'b0;
            rejected <= 1'b0;
            busy <= 1'b0;
            for (int i = 0; i < TPL_NUM_REGS; i++) begin
                regs[i] <= TPL_RST_VAL;
            end
        end else begin
            state <= next_state;
            index <= next_index;
            slot <= next_slot;
            done <= next_done;
            rejected <= next_rejected;
            busy <= next_busy;
            regs <= next_regs;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign busy_o = busy;
    assign done_o = done;
    assign rejected_o = rejected;
    assign tx_carrier_clock_ctrl_o = regs[TPL_SLOT_CLK];
    assign tx_modulation_cfg_o = regs[TPL_SLOT_MOD];
    assign tx_undershoot_shape_o = regs[TPL_SLOT_UND];
    assign tx_overshoot_shape_o = regs[TPL_SLOT_OVR];
    assign tx_driver_ctrl_o = regs[TPL_SLOT_DRV];
    assign antenna_ctrl_o = regs[TPL_SLOT_ANT];

endmodule : tpl_loader
`default_nettype wire

// ### tpl_loader_sva.sv
// checker: assertions on the preset loader ports
`timescale 1ns/1ns
`default_nettype none
module tpl_loader_chk (
    // clock, reset, request
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic load_protocol_preset_cmd_i,
    input wire logic [3:0] protocol_index_i,
    // status
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic rejected_o,
    // registers
    input wire logic [31:0] tx_carrier_clock_ctrl_o,
    input wire logic [31:0] tx_modulation_cfg_o,
    input wire logic [31:0] tx_undershoot_shape_o,
    input wire logic [31:0] tx_overshoot_shape_o,
    input wire logic [31:0] tx_driver_ctrl_o,
    input wire logic [31:0] antenna_ctrl_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    wire logic take = load_protocol_preset_cmd_i && !busy_o;
    wire logic good = protocol_index_i < 4'hA;
    wire logic [191:0] regs = {tx_carrier_clock_ctrl_o, tx_modulation_cfg_o,
        tx_undershoot_shape_o, tx_overshoot_shape_o, tx_driver_ctrl_o, antenna_ctrl_o};
    a_busy_known: assert property (take && good |=> busy_o [*7])
        else $error("busy not held for a known preset");
    a_done_known: assert property (take && good |-> ##7 done_o)
        else $error("done missing after preset load");
    a_done_pulse: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    a_ant_done: assert property (done_o |-> antenna_ctrl_o == 32'h10)
        else $error("antenna value wrong at done");
    a_clk_a106: assert property (take && protocol_index_i == 4'h0
        |-> ##2 tx_carrier_clock_ctrl_o == 32'h74)
        else $error("clock control wrong for A106");
    a_drv_a212: assert property (take && protocol_index_i == 4'h1
        |-> ##6 tx_driver_ctrl_o == 32'hDBCF043)
        else $error("driver value wrong for A212");
    a_ovr_b424: assert property (take && protocol_index_i == 4'h6
        |-> ##5 tx_overshoot_shape_o == 32'h1FE0013)
        else $error("overshoot wrong for B424");
    a_reject_bad: assert property (take && !good |-> ##[1:2] rejected_o)
        else $error("unknown index not rejected");
    a_reject_hold: assert property (take && !good |=> $stable(regs) [*2])
        else $error("registers changed on rejection");
    cover property (take && good);
    cover property (rejected_o);
    cover property (load_protocol_preset_cmd_i && busy_o);
endmodule : tpl_loader_chk
bind tpl_loader tpl_loader_chk i_chk (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .load_protocol_preset_cmd_i(load_protocol_preset_cmd_i),
    .protocol_index_i(protocol_index_i), .busy_o(busy_o), .done_o(done_o),
    .rejected_o(rejected_o), .tx_carrier_clock_ctrl_o(tx_carrier_clock_ctrl_o),
    .tx_modulation_cfg_o(tx_modulation_cfg_o), .tx_undershoot_shape_o(tx_undershoot_shape_o),
    .tx_overshoot_shape_o(tx_overshoot_shape_o), .tx_driver_ctrl_o(tx_driver_ctrl_o),
    .antenna_ctrl_o(antenna_ctrl_o));
`default_nettype wire

// ### tpl_host_model.sv
// partner: host model that issues preset requests
`timescale 1ns/1ns
`default_nettype none
module tpl_host_model (
    // clock
    input wire logic clock_i,
    // request to the loader
    output var logic cmd_o,
    output var logic [3:0] index_o
);
    initial begin
        cmd_o = 1'b0;
        index_o = 4'h0;
    end
    // one-cycle request, index scrambled once released
    task automatic send(input logic [3:0] idx);
        @(posedge clock_i);
        cmd_o <= 1'b1;
        index_o <= idx;
        @(posedge clock_i);
        cmd_o <= 1'b0;
        index_o <= ~idx;
    endtask : send
endmodule : tpl_host_model
`default_nettype wire

// ### testbench.sv
// testbench: self-checking bench for the preset loader
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    wire logic cmd, busy, done, rej;
    wire logic [3:0] idx;
    wire [31:0] r [0:5];
    wire [191:0] regs = {r[0], r[1], r[2], r[3], r[4], r[5]};
    int fails = 0;
    int checked = 0;
    initial begin
        forever #20 clock_i = ~clock_i;
    end
    tpl_host_model i_host (.clock_i(clock_i), .cmd_o(cmd), .index_o(idx));
    tpl_loader i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
        .load_protocol_preset_cmd_i(cmd), .protocol_index_i(idx), .busy_o(busy),
        .done_o(done), .rejected_o(rej), .tx_carrier_clock_ctrl_o(r[0]),
        .tx_modulation_cfg_o(r[1]), .tx_undershoot_shape_o(r[2]),
        .tx_overshoot_shape_o(r[3]), .tx_driver_ctrl_o(r[4]), .antenna_ctrl_o(r[5]));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [191:0] preset_exp(input logic [3:0] i);
        logic [159:0] v;
        case (i)
            4'h0: v = {32'h74, 32'h2350, 32'h17, 32'h0, 32'hDBCF43};
            4'h1: v = {32'h82, 32'h2350, 32'h17, 32'h0, 32'hDBCF043};
            4'h2: v = {32'h82, 32'h650, 32'h5, 32'h0, 32'hDBCF43};
            4'h3: v = {32'h82, 32'h150, 32'h1, 32'h0, 32'hF9EF45};
            4'h4: v = {32'h8E, 32'h0, 32'h0, 32'h0, 32'h3A4756};
            4'h5: v = {32'h8E, 32'h0, 32'h0, 32'h0, 32'h39C746};
            4'h6: v = {32'h78E, 32'h0, 32'h0, 32'h1FE0013, 32'h71CF54};
            4'h7: v = {32'h78E, 32'h0, 32'h0, 32'h7E000D, 32'h69AF32};
            4'h8: v = {32'h8E, 32'h0, 32'h0, 32'h0, 32'h39E744};
            default: v = {32'h8E, 32'h0, 32'h0, 32'h0, 32'h39EF33};
        endcase
        preset_exp = {v, 32'h10};
    endfunction : preset_exp
    task automatic check(input logic [191:0] seen, input logic [191:0] want);
        checked++;
        if (seen !== want) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    task automatic print_verdict;
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    // wait for done or rejected, bounded
    task automatic wait_ev(output logic [1:0] ev);
        int n;
        ev = 2'b00;
        n = 0;
        while (ev === 2'b00 && n < 20) begin
            @(negedge clock_i);
            ev = {done, rej};
            n++;
        end
        if (ev === 2'b00) begin
            fails++;
            print_verdict();
        end
    endtask : wait_ev
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [1:0] ev;
        repeat (16) @(posedge clock_i);
        rst_b_i <= 1'b1;
        check(regs, 192'h0);
        // every preset, back to back
        for (int k = 0; k < 10; k++) begin
            i_host.send(k[3:0]);
            wait_ev(ev);
            check({190'h0, ev}, 192'h2);
            check(regs, preset_exp(k[3:0]));
            check({191'h0, busy}, 192'h1);
        end
        // unknown indices leave registers alone
        for (int k = 10; k < 16; k++) begin
            i_host.send(k[3:0]);
            wait_ev(ev);
            check({190'h0, ev}, 192'h1);
            check(regs, preset_exp(4'h9));
            check({191'h0, busy}, 192'h0);
        end
        // request while busy is ignored
        i_host.send(4'h1);
        i_host.send(4'hF);
        wait_ev(ev);
        check({190'h0, ev}, 192'h2);
        check(regs, preset_exp(4'h1));
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
